// ### pkg/sfr_pkg.sv
// constants and bundles for the serial flash multi-lane read front end
// assumes a single system clock domain; link pins arrive unsynchronised
package sfr_pkg;
  localparam int ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  localparam int CNT_W = 6;
  localparam int BUF_DEPTH = 2;
  localparam logic [7:0] OPC_FAST = 8'h0B;
  localparam logic [7:0] OPC_TWO_OUT = 8'h3B;
  localparam logic [7:0] OPC_FOUR_OUT = 8'h6B;
  localparam logic [7:0] OPC_TWO_ADDR = 8'hBB;
  localparam logic [3:0] MODE_STAY = 4'hA;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 4;
  localparam int QUAD_EN_BIT = 1;
  localparam logic [CNT_W-1:0] OPC_EDGES = 6'h08;
  localparam logic [CNT_W-1:0] ADDR_EDGES_ONE = 6'h18;
  localparam logic [CNT_W-1:0] ADDR_EDGES_TWO = 6'h0C;
  localparam logic [CNT_W-1:0] DUMMY_EDGES = 6'h08;
  localparam logic [CNT_W-1:0] MODE_EDGES_TWO = 6'h04;
  localparam logic [3:0] EXIT_PULSE_MAX = 4'h8;
  localparam logic [2:0] LANE_ONE = 3'h1;
  localparam logic [2:0] LANE_TWO = 3'h2;
  localparam logic [2:0] LANE_FOUR = 3'h4;

  typedef enum logic [1:0] {SFR_RD_FAST, SFR_RD_TWO_OUT, SFR_RD_FOUR_OUT, SFR_RD_TWO_ADDR} sfr_kind_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [LANES-1:0] dl;
  } sfr_link_in_t;

  typedef struct packed {
    logic [LANES-1:0] dl;
    logic [LANES-1:0] oe;
  } sfr_link_out_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } sfr_arr_req_t;

  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } sfr_arr_rsp_t;
endpackage

// ### hdl/sfr_sync2.sv
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are levels from outside the clock domain
module sfr_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second; reset to the idle pin levels
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ### hdl/sfr_read_engine.sv
// read command engine of a serial flash: fast, two/four lane output, two lane address reads
// assumes sck is far slower than sys_clk_in (8x or more); array answers over valid/ready
// What this block does
// - fast read: opcode, 24-bit address, one dummy byte, sampled on rising sck
// - fast read data leaves on line zero, changing on falling sck
// - any start address; address advances by one per output byte
// - address past the top wraps to zero and streaming continues
// - select high during data ends the read and stops the drivers
// - read commands are ignored while program, erase or register write runs, except frames in continuous mode
// - two-lane output read uses fast read framing on line zero
// - two-lane output read drives two bits per clock on lines zero and one
// - four-lane output read drives four bits per clock on lines zero to three
// - four-lane reads need the configuration four-lane enable bit set
// - two-lane address read takes address and mode byte two bits per edge
// - after the mode byte, data leaves two bits per clock
// - only the upper mode nibble is decoded, lower nibble ignored
// - upper nibble A keeps continuous mode; next frame starts with address
// - any other nibble leaves continuous mode at the next select cycle
// - a select pulse of eight clocks or fewer without a command leaves continuous mode
// - fast read opcode is 0B, three address bytes, one dummy byte
// - two-lane address read has no dummy byte; data follows the mode byte
module sfr_read_engine
  import sfr_pkg::*;
#(
  parameter logic [sfr_pkg::ADDR_W-1:0] ADDR_LAST = 24'hFFFFFF
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire sfr_pkg::sfr_link_in_t link_in,
  output sfr_pkg::sfr_link_out_t link_out,
  input wire logic busy_in,
  input wire logic [7:0] config_reg_in,
  output sfr_pkg::sfr_arr_req_t arr_req_out,
  input wire logic arr_req_ready_in,
  input wire sfr_pkg::sfr_arr_rsp_t arr_rsp_in,
  output logic arr_rsp_ready_out,
  output logic execute_in_place_out
);
  import sfr_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_MODE, ST_DATA,
                            ST_IGNORE} sfr_state_t;

  sfr_link_in_t pin_s;
  logic sck_prev_q, cs_prev_q;
  logic rise, fall, cs_start, cs_end;
  sfr_state_t state_q;
  sfr_kind_t kind_q;
  logic [CNT_W-1:0] edge_q;
  logic [ADDR_W-1:0] shift_q;
  logic [ADDR_W-1:0] addr_q;
  logic [3:0] txn_rise_q;
  logic stay_q;
  logic two_in_q;
  logic [2:0] lanes_q;
  logic [BYTE_W-1:0] out_byte_q;
  logic [3:0] bits_left_q;
  logic [BYTE_W-1:0] buf_q [BUF_DEPTH];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] count_q, count_d;
  logic [1:0] inflight_q, drop_q;
  logic [1:0] in_bits;
  logic [CNT_W-1:0] edge_inc;
  logic [CNT_W-1:0] phase_len;
  logic phase_done;
  logic [7:0] opc_full;
  logic push, pop, rsp_take, req_fire, fetch_ok;
  logic [2:0] credits;

  // select resets high so release of reset shows no false frame start
  sfr_sync2 #(.W($bits(sfr_link_in_t)), .RST_VAL({1'b1, 1'b0, 4'h0})) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(link_in),
    .q_out(pin_s)
  );

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= pin_s.sck;
      cs_prev_q <= pin_s.cs_n;
    end
  end

  // edges only count while select is low
  assign rise = pin_s.sck & ~sck_prev_q & ~pin_s.cs_n;
  assign fall = ~pin_s.sck & sck_prev_q & ~pin_s.cs_n;
  assign cs_start = cs_prev_q & ~pin_s.cs_n;
  assign cs_end = ~cs_prev_q & pin_s.cs_n;

  // sampling lanes: line zero only, or lines one and zero msb first
  always_comb begin
    in_bits = two_in_q ? pin_s.dl[1:0] : {1'b0, pin_s.dl[0]};
    edge_inc = edge_q + 6'h01;
    opc_full = {shift_q[6:0], pin_s.dl[0]};
    phase_len = OPC_EDGES;
    if (state_q == ST_ADDR) begin
      phase_len = two_in_q ? ADDR_EDGES_TWO : ADDR_EDGES_ONE;
    end else if (state_q == ST_DUMMY) begin
      phase_len = DUMMY_EDGES;
    end else if (state_q == ST_MODE) begin
      phase_len = MODE_EDGES_TWO;
    end
    phase_done = rise && (edge_inc == phase_len);
  end

  // command sequencer
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      kind_q <= SFR_RD_FAST;
      edge_q <= '0;
      two_in_q <= 1'b0;
      lanes_q <= LANE_ONE;
    end else if (cs_end) begin
      state_q <= ST_IDLE;
      edge_q <= '0;
    end else if (cs_start) begin
      edge_q <= '0;
      if (stay_q) begin
        state_q <= ST_ADDR;
        kind_q <= SFR_RD_TWO_ADDR;
        two_in_q <= 1'b1;
        lanes_q <= LANE_TWO;
      end else begin
        state_q <= ST_OPC;
        two_in_q <= 1'b0;
      end
    end else if (rise) begin
      edge_q <= phase_done ? '0 : edge_inc;
      case (state_q)
        ST_OPC: begin
          if (phase_done) begin
            if (busy_in) begin
              state_q <= ST_IGNORE;
            end else if (opc_full == OPC_FAST) begin
              state_q <= ST_ADDR;
              kind_q <= SFR_RD_FAST;
              lanes_q <= LANE_ONE;
            end else if (opc_full == OPC_TWO_OUT) begin
              state_q <= ST_ADDR;
              kind_q <= SFR_RD_TWO_OUT;
              lanes_q <= LANE_TWO;
            end else if (opc_full == OPC_FOUR_OUT && config_reg_in[QUAD_EN_BIT]) begin
              state_q <= ST_ADDR;
              kind_q <= SFR_RD_FOUR_OUT;
              lanes_q <= LANE_FOUR;
            end else if (opc_full == OPC_TWO_ADDR) begin
              state_q <= ST_ADDR;
              kind_q <= SFR_RD_TWO_ADDR;
              lanes_q <= LANE_TWO;
              two_in_q <= 1'b1;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          if (phase_done) begin
            state_q <= (kind_q == SFR_RD_TWO_ADDR) ? ST_MODE : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (phase_done) begin
            state_q <= ST_DATA;
          end
        end
        ST_MODE: begin
          if (phase_done) begin
            state_q <= ST_DATA;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // input shifter, msb first on one or two lanes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= '0;
    end else if (rise) begin
      if (two_in_q) begin
        shift_q <= {shift_q[ADDR_W-3:0], in_bits};
      end else begin
        shift_q <= {shift_q[ADDR_W-2:0], in_bits[0]};
      end
    end
  end

  // continuous two-lane mode bookkeeping
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txn_rise_q <= '0;
      stay_q <= 1'b0;
      execute_in_place_out <= 1'b0;
    end else begin
      if (cs_start) begin
        txn_rise_q <= '0;
      end else if (rise && txn_rise_q != 4'hF) begin
        txn_rise_q <= txn_rise_q + 4'h1;
      end
      if (state_q == ST_MODE && phase_done) begin
        // only the upper nibble matters
        execute_in_place_out <= (shift_q[MODE_HI-2:MODE_LO-2] == MODE_STAY);
      end else if (cs_end && stay_q && state_q == ST_ADDR && txn_rise_q <= EXIT_PULSE_MAX) begin
        execute_in_place_out <= 1'b0;
      end
      if (cs_end) begin
        if (state_q == ST_ADDR && txn_rise_q <= EXIT_PULSE_MAX) begin
          stay_q <= 1'b0;
        end else if (state_q == ST_DATA) begin
          stay_q <= execute_in_place_out;
        end else if (state_q != ST_ADDR) begin
          stay_q <= 1'b0;
        end
      end
    end
  end

  // array fetch: one request presented at a time, up to two outstanding; credits cover the buffer
  assign credits = 3'(BUF_DEPTH) - 3'(count_q) - 3'(inflight_q) - 3'(arr_req_out.valid);
  assign fetch_ok = (state_q == ST_DUMMY || state_q == ST_MODE || state_q == ST_DATA)
                    && drop_q == '0 && !arr_req_out.valid && credits != '0;
  assign req_fire = arr_req_out.valid & arr_req_ready_in;
  assign rsp_take = arr_rsp_in.valid & arr_rsp_ready_out;
  assign push = rsp_take & (drop_q == '0) & (state_q != ST_IDLE);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arr_req_out <= '0;
      addr_q <= '0;
    end else if (cs_end) begin
      arr_req_out.valid <= 1'b0;
    end else if (rise && state_q == ST_ADDR && phase_done) begin
      // last address bit arrives with this edge
      addr_q <= two_in_q ? {shift_q[ADDR_W-3:0], in_bits} : {shift_q[ADDR_W-2:0], in_bits[0]};
    end else if (fetch_ok) begin
      arr_req_out.valid <= 1'b1;
      arr_req_out.addr <= addr_q;
    end else if (req_fire) begin
      arr_req_out.valid <= 1'b0;
      addr_q <= (addr_q == ADDR_LAST) ? '0 : addr_q + 24'h000001;
    end
  end

  // stale answers after an aborted read are drained, never shown
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inflight_q <= '0;
      drop_q <= '0;
    end else if (cs_end) begin
      inflight_q <= '0;
      drop_q <= drop_q + inflight_q + 2'(req_fire) - 2'(rsp_take);
    end else begin
      inflight_q <= inflight_q + 2'(req_fire) - 2'((drop_q == '0) & rsp_take);
      if (rsp_take && drop_q != '0) begin
        drop_q <= drop_q - 2'h1;
      end
    end
  end

  // two-entry buffer between array and output shifter
  assign pop = fall && state_q == ST_DATA && bits_left_q == '0 && count_q != '0;

  always_comb begin
    count_d = count_q + 2'(push) - 2'(pop);
    if (cs_end) begin
      count_d = '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= '0;
      arr_rsp_ready_out <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      count_q <= count_d;
      // full buffer stalls the array side
      arr_rsp_ready_out <= (count_d < 2'(BUF_DEPTH)) || (drop_q != '0);
      if (cs_end) begin
        wr_ptr_q <= 1'b0;
        rd_ptr_q <= 1'b0;
      end else begin
        if (push) begin
          buf_q[wr_ptr_q] <= arr_rsp_in.data;
          wr_ptr_q <= ~wr_ptr_q;
        end
        if (pop) begin
          rd_ptr_q <= ~rd_ptr_q;
        end
      end
    end
  end

  // output shifter on falling sck; drivers only in the data phase
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_out <= '0;
      out_byte_q <= '0;
      bits_left_q <= '0;
    end else if (state_q != ST_DATA || cs_end) begin
      link_out <= '0;
      bits_left_q <= '0;
    end else if (fall) begin
      // an underrun repeats zeros rather than stalling the host clock
      case (lanes_q)
        LANE_FOUR: begin
          link_out.oe <= 4'hF;
          if (bits_left_q == '0) begin
            link_out.dl <= pop ? buf_q[rd_ptr_q][7:4] : 4'h0;
            out_byte_q <= pop ? {buf_q[rd_ptr_q][3:0], 4'h0} : 8'h00;
            bits_left_q <= 4'h4;
          end else begin
            link_out.dl <= out_byte_q[7:4];
            out_byte_q <= {out_byte_q[3:0], 4'h0};
            bits_left_q <= bits_left_q - 4'h4;
          end
        end
        LANE_TWO: begin
          link_out.oe <= 4'h3;
          if (bits_left_q == '0) begin
            link_out.dl <= {2'b00, pop ? buf_q[rd_ptr_q][7:6] : 2'b00};
            out_byte_q <= pop ? {buf_q[rd_ptr_q][5:0], 2'b00} : 8'h00;
            bits_left_q <= 4'h6;
          end else begin
            link_out.dl <= {2'b00, out_byte_q[7:6]};
            out_byte_q <= {out_byte_q[5:0], 2'b00};
            bits_left_q <= bits_left_q - 4'h2;
          end
        end
        default: begin
          link_out.oe <= 4'h1;
          if (bits_left_q == '0) begin
            link_out.dl <= {3'b000, pop ? buf_q[rd_ptr_q][7] : 1'b0};
            out_byte_q <= pop ? {buf_q[rd_ptr_q][6:0], 1'b0} : 8'h00;
            bits_left_q <= 4'h7;
          end else begin
            link_out.dl <= {3'b000, out_byte_q[7]};
            out_byte_q <= {out_byte_q[6:0], 1'b0};
            bits_left_q <= bits_left_q - 4'h1;
          end
        end
      endcase
    end
  end
endmodule

// ### testbench/sfr_read_engine_assertions.sv
// port-level checks for the multi-lane read engine
// assumes bind onto sfr_read_engine, one clock domain
module sfr_read_engine_assertions
  import sfr_pkg::*;
#(
  parameter logic [sfr_pkg::ADDR_W-1:0] ADDR_LAST = 24'hFFFFFF
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire sfr_pkg::sfr_link_in_t link_in,
  input wire sfr_pkg::sfr_link_out_t link_out,
  input wire logic busy_in,
  input wire logic [7:0] config_reg_in,
  input wire sfr_pkg::sfr_arr_req_t arr_req_out,
  input wire logic arr_req_ready_in,
  input wire sfr_pkg::sfr_arr_rsp_t arr_rsp_in,
  input wire logic arr_rsp_ready_out,
  input wire logic execute_in_place_out
);
  logic [ADDR_W-1:0] last_q;
  logic have_q;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // last accepted address; forgotten when select rises, since a new frame restarts it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      have_q <= 1'b0;
      last_q <= '0;
    end else if (link_in.cs_n) begin
      have_q <= 1'b0;
    end else if (arr_req_out.valid && arr_req_ready_in) begin
      have_q <= 1'b1;
      last_q <= arr_req_out.addr;
    end
  end
  chk_oe_needs_sel: assert property (link_in.cs_n [*5] |-> link_out.oe == 4'h0)
    else $error("lines driven while deselected");
  chk_oe_lane_shape: assert property (link_out.oe inside {4'h0, 4'h1, 4'h3, 4'hF})
    else $error("odd lane enable set");
  chk_quad_needs_cfg: assert property (link_out.oe == 4'hF |-> config_reg_in[QUAD_EN_BIT])
    else $error("four lanes without enable bit");
  chk_req_holds: assert property (arr_req_out.valid && !arr_req_ready_in && !link_in.cs_n
    |=> arr_req_out.valid && $stable(arr_req_out.addr)) else $error("request dropped");
  chk_addr_step: assert property (arr_req_out.valid && have_q
    |-> arr_req_out.addr == ((last_q == ADDR_LAST) ? '0 : last_q + 1'b1))
    else $error("address did not step");
  chk_req_in_range: assert property (arr_req_out.valid |-> arr_req_out.addr <= ADDR_LAST)
    else $error("address beyond array top");
  // mode is decided at the end of the mode byte, before any data line is driven
  chk_mode_at_gap: assert property ($changed(execute_in_place_out) |-> link_out.oe == 4'h0)
    else $error("mode changed while driving data");
  chk_dl_after_fall: assert property ($changed(link_out.dl & link_out.oe)
    |-> !$past(link_in.sck)) else $error("data changed after rising clock");
  cover property (link_out.oe == 4'hF);
  cover property ($rose(execute_in_place_out));
  cover property (!arr_rsp_ready_out);
endmodule

bind sfr_read_engine sfr_read_engine_assertions #(.ADDR_LAST(ADDR_LAST)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link_in(link_in), .link_out(link_out),
  .busy_in(busy_in), .config_reg_in(config_reg_in), .arr_req_out(arr_req_out),
  .arr_req_ready_in(arr_req_ready_in), .arr_rsp_in(arr_rsp_in),
  .arr_rsp_ready_out(arr_rsp_ready_out), .execute_in_place_out(execute_in_place_out)
);

// ### testbench/sfr_host_model.sv
// host side of the serial link: frames read commands, captures data lines
// assumes clk_in is the system clock; sck half period is four of its cycles
module sfr_host_model
  import sfr_pkg::*;
(
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] dl_out,
  output logic [3:0] oe_out,
  input wire logic [3:0] dl_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx [8];
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    dl_out = 4'h0;
    oe_out = 4'h0;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // release mask k applies late in the high phase, after the device has sampled
  task automatic bitc(input logic [3:0] v, input logic [3:0] e, input logic [3:0] k,
      output logic [3:0] s);
    dl_out = v;
    oe_out = e;
    half();
    s = dl_in;
    sck_out = 1'b1;
    repeat (3) @(negedge clk_in);
    oe_out = oe_out & k;
    @(negedge clk_in);
    sck_out = 1'b0;
  endtask
  // op clear: continuous mode, frame opens with the address
  task automatic frame(input logic [7:0] opc, input bit op, input logic [23:0] a,
      input logic [7:0] m, input int ln, input int nb, input int cut);
    logic [3:0] s;
    logic [63:0] sh;
    cs_n_out = 1'b0;
    half();
    if (op) for (int i = 7; i >= 0; i--) bitc({3'h0, opc[i]}, 4'h1, 4'hF, s);
    if (opc == OPC_TWO_ADDR) begin
      sh = {a, m, 32'h0};
      for (int i = 0; i < 16; i++) bitc({2'h0, sh[63-2*i -: 2]}, 4'h3,
          (i == 15) ? 4'h0 : 4'hF, s);
    end else begin
      sh = {a, 40'h0};
      for (int i = 0; i < 32; i++) bitc({3'h0, sh[63-i]}, (i < 24) ? 4'h1 : 4'h0, 4'hF, s);
    end
    for (int b = 0; b < nb; b++) begin
      for (int i = 0; i < 8 / ln; i++) begin
        bitc(4'h0, 4'h0, 4'h0, s);
        rx[b] = (ln == 4) ? {rx[b][3:0], s} : (ln == 2) ? {rx[b][5:0], s[1:0]} : {rx[b][6:0], s[0]};
      end
    end
    repeat (cut) bitc(4'h0, 4'h0, 4'h0, s);
    cs_n_out = 1'b1;
    repeat (3) half();
  endtask
  task automatic pulse(input int n);
    logic [3:0] s;
    cs_n_out = 1'b0;
    half();
    repeat (n) bitc(4'h3, 4'h3, 4'h0, s);
    cs_n_out = 1'b1;
    repeat (3) half();
  endtask
endmodule

// ### testbench/sfr_read_engine_tb.sv
// self-checking bench for the multi-lane read engine
// assumes host pins come from sfr_host_model and the array from the process below
module sfr_read_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sfr_pkg::*;
  localparam logic [23:0] LAST = 24'h3FFFFF;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic busy = 1'b0;
  logic stall = 1'b0;
  logic tgl = 1'b0;
  logic req_rdy = 1'b0;
  logic saw_oe, saw_full, rsp_rdy, execute_in_place, h_cs, h_sck;
  logic [7:0] cfg = 8'h02;
  logic [3:0] h_dl, h_oe, pin;
  sfr_link_in_t lin;
  sfr_link_out_t lout;
  sfr_arr_req_t req;
  sfr_arr_rsp_t rsp;
  logic [23:0] q[$];
  int failures = 0;
  int num_checks = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  // a released line toggles so a stale value is never read as data
  always @(posedge sys_clk_in) tgl <= ~tgl;
  always_comb for (int i = 0; i < 4; i++) pin[i] = lout.oe[i] ? lout.dl[i] : h_oe[i] ? h_dl[i] : tgl;
  assign lin = {h_cs, h_sck, pin};
  sfr_host_model host (.clk_in(sys_clk_in), .cs_n_out(h_cs), .sck_out(h_sck), .dl_out(h_dl),
    .oe_out(h_oe), .dl_in(pin));
  sfr_read_engine #(.ADDR_LAST(LAST)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .link_in(lin), .link_out(lout), .busy_in(busy), .config_reg_in(cfg), .arr_req_out(req),
    .arr_req_ready_in(req_rdy), .arr_rsp_in(rsp), .arr_rsp_ready_out(rsp_rdy),
    .execute_in_place_out(execute_in_place));
  function automatic logic [7:0] f(logic [23:0] a);
    return a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h3C;
  endfunction
  // array: one byte per request, in order; stall holds off requests half the time
  always @(posedge sys_clk_in) begin
    saw_oe <= saw_oe | (|lout.oe);
    saw_full <= saw_full | !rsp_rdy;
    if (req.valid && req_rdy) q.push_back(req.addr);
    if (rsp.valid && rsp_rdy) rsp.valid <= 1'b0;
    else if (!rsp.valid && q.size() > 0) rsp <= {1'b1, f(q.pop_front())};
    req_rdy <= !(stall && tgl);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [23:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      chk(host.rx[i], f(a));
      a = (a == LAST) ? 24'h0 : a + 24'h1;
    end
  endtask
  task automatic t_fast_wrap();
    host.frame(OPC_FAST, 1, LAST - 24'h1, 8'h00, 1, 4, 0);
    rd_chk(LAST - 24'h1, 4);
  endtask
  task automatic t_lanes();
    host.frame(OPC_TWO_OUT, 1, 24'h123456, 8'h00, 2, 3, 0);
    rd_chk(24'h123456, 3);
    stall = 1'b1;
    saw_full = 1'b0;
    host.frame(OPC_FOUR_OUT, 1, 24'h2ABCDE, 8'h00, 4, 4, 0);
    rd_chk(24'h2ABCDE, 4);
    chk({7'h0, saw_full}, 8'h01);
    stall = 1'b0;
  endtask
  task automatic t_refuse();
    busy = 1'b1;
    saw_oe = 1'b0;
    host.frame(OPC_FAST, 1, 24'h000100, 8'h00, 1, 1, 0);
    chk({7'h0, saw_oe}, 8'h00);
    busy = 1'b0;
    cfg = 8'hFD;
    host.frame(OPC_FOUR_OUT, 1, 24'h000100, 8'h00, 4, 2, 0);
    chk({7'h0, saw_oe}, 8'h00);
    cfg = 8'h02;
  endtask
  task automatic t_abort();
    host.frame(OPC_FAST, 1, 24'h000010, 8'h00, 1, 1, 3);
    rd_chk(24'h000010, 1);
    host.frame(OPC_TWO_OUT, 1, 24'h000200, 8'h00, 2, 2, 0);
    rd_chk(24'h000200, 2);
  endtask
  task automatic t_cont();
    host.frame(OPC_TWO_ADDR, 1, 24'h155AA0, 8'hA5, 2, 2, 0);
    rd_chk(24'h155AA0, 2);
    chk({7'h0, execute_in_place}, 8'h01);
    host.frame(OPC_TWO_ADDR, 0, 24'h3F0001, 8'h5A, 2, 2, 0);
    rd_chk(24'h3F0001, 2);
    chk({7'h0, execute_in_place}, 8'h00);
    host.frame(OPC_FAST, 1, 24'h000300, 8'h00, 1, 1, 0);
    rd_chk(24'h000300, 1);
    host.frame(OPC_TWO_ADDR, 1, 24'h000400, 8'hA0, 2, 1, 0);
    host.pulse(4);
    chk({7'h0, execute_in_place}, 8'h00);
    host.frame(OPC_FAST, 1, 24'h000500, 8'h00, 1, 1, 0);
    rd_chk(24'h000500, 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rsp = '0;
    repeat (8) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    t_fast_wrap();
    t_lanes();
    t_refuse();
    t_abort();
    t_cont();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    report_and_stop();
  end
endmodule
